// ===== core/adcseq_pkg.sv
// Package with register map, field layout and timing constants of the conversion sequencer.
package adcseq_pkg;

  // Register word addresses on the Avalon-MM word bus.
  localparam logic [2:0] ADDR_CTRL0   = 3'h0;
  localparam logic [2:0] ADDR_CTRL1   = 3'h1;
  localparam logic [2:0] ADDR_RESHIGH = 3'h2;
  localparam logic [2:0] ADDR_RESLOW  = 3'h3;
  localparam logic [2:0] ADDR_STATUS  = 3'h4;

  // Control register 0 field positions.
  localparam int CTRL0_ENABLE_BIT = 7;
  localparam int CTRL0_REFLOW_BIT = 6;
  localparam int CTRL0_REFOUT_BIT = 5;
  localparam int CTRL0_CONTINUOUS_MODE_BIT   = 4;
  localparam int CTRL0_CHAN_LSB   = 0;
  // Control register 1 field positions.
  localparam int CTRL1_REFHIGH_BIT = 7;
  localparam int CTRL1_MODE_LSB    = 0;
  // Status register field positions.
  localparam int STAT_POWERED_BIT = 0;
  localparam int STAT_BUSY_BIT    = 1;

  // Reset values.
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

  // Channel code that shorts the differential inputs together.
  localparam logic [3:0] CHAN_OFFSET_CAL = 4'hF;

  // Timing in system clock cycles at 20 MHz.
  localparam int IDLE_POWERDOWN_CYC = 160;
  localparam int POWERUP_CYC        = 40;
  localparam int FIRST_CONV_CYC     = 5129;
  localparam int CONTINUOUS_MODE_CONV_CYC      = 256;
  localparam int CNT_W              = 13;

  localparam logic [CNT_W-1:0] IDLE_LAST    = CNT_W'(IDLE_POWERDOWN_CYC - 1);
  localparam logic [CNT_W-1:0] POWERUP_LAST = CNT_W'(POWERUP_CYC - 1);
  localparam logic [CNT_W-1:0] CONTINUOUS_MODE_LAST    = CNT_W'(CONTINUOUS_MODE_CONV_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO     = '0;
  localparam logic [CNT_W-1:0] CNT_ONE      = CNT_W'(1);

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_POWERUP,
    ST_CONVERT
  } adcseq_state_t;

  // Analog-side configuration carried as one group.
  typedef struct packed {
    logic [3:0] channelSelect;
    logic [2:0] inputModeSelect;
    logic       refLevelHighBit;
    logic       refLevelLowBit;
    logic       refPinOutputEnable;
    logic       offsetShort;
    logic       powerOn;
  } adcseq_analog_t;

  // Whole state of the sequencer.
  typedef struct packed {
    adcseq_state_t   state;
    logic [CNT_W-1:0] cnt;
    logic            powered;
    logic            firstDone;
    logic            convEnable;
    logic            continuousMode;
    logic            refLevelLowBit;
    logic            refPinOutputEnable;
    logic [3:0]      channelSelect;
    logic [2:0]      inputModeSelect;
    logic            refLevelHighBit;
    logic [7:0]      resultHighByte;
    logic [7:0]      resultLowByte;
    logic            irqPulse;
    logic            readValid;
    logic [31:0]     readData;
  } adcseq_regs_t;

endpackage

// ===== core/adcseq_sequencer.sv
// Conversion sequencer for a sigma-delta converter with an Avalon-MM register slave.
module adcseq_sequencer
  import adcseq_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Avalon-MM slave.
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Modulator side.
  input  wire logic [12:0] modResult,
  input  wire logic        modOverflow,
  output adcseq_analog_t   analogCtrl,
  // Interrupt controller.
  output logic             convDoneIrq
);

  adcseq_regs_t r_reg;
  adcseq_regs_t r_next;

  logic wrCtrl0;
  logic wrCtrl1;
  logic startReq;
  logic lastCycle;

  // Decode a write that lands this cycle; the slave answers reads one cycle later.
  assign wrCtrl0  = write && (address == ADDR_CTRL0);
  assign wrCtrl1  = write && (address == ADDR_CTRL1);
  assign startReq = wrCtrl0 && writedata[CTRL0_ENABLE_BIT];

  // Writes complete at once; a read waits until its data register is loaded.
  assign waitrequest = read && !r_reg.readValid;
  assign readdata    = r_reg.readData;
  assign convDoneIrq = r_reg.irqPulse;

  // Analog outputs come straight from state flip-flops, except offsetShort, which is decoded from channelSelect.
  always_comb begin
    analogCtrl.channelSelect      = r_reg.channelSelect;
    analogCtrl.inputModeSelect    = r_reg.inputModeSelect;
    analogCtrl.refLevelHighBit    = r_reg.refLevelHighBit;
    analogCtrl.refLevelLowBit     = r_reg.refLevelLowBit;
    analogCtrl.refPinOutputEnable = r_reg.refPinOutputEnable;
    analogCtrl.offsetShort        = (r_reg.channelSelect == CHAN_OFFSET_CAL);
    analogCtrl.powerOn            = r_reg.powered;
  end

  assign lastCycle = (r_reg.cnt == CNT_ONE);

  // Next-state logic for the whole block.
  always_comb begin
    r_next          = r_reg;
    r_next.irqPulse = 1'b0;

    // Register writes; the enable bit only ever sets by software.
    if (wrCtrl0) begin
      r_next.refLevelLowBit     = writedata[CTRL0_REFLOW_BIT];
      r_next.refPinOutputEnable = writedata[CTRL0_REFOUT_BIT];
      r_next.continuousMode     = writedata[CTRL0_CONTINUOUS_MODE_BIT];
      r_next.channelSelect      = writedata[CTRL0_CHAN_LSB +: 4];
    end
    if (wrCtrl1) begin
      r_next.refLevelHighBit = writedata[CTRL1_REFHIGH_BIT];
      r_next.inputModeSelect = writedata[CTRL1_MODE_LSB +: 3];
    end

    // Sequencer.
    unique case (r_reg.state)
      ST_IDLE: begin
        if (startReq) begin
          r_next.convEnable = 1'b1;
          r_next.firstDone  = 1'b0;
          if (r_reg.powered) begin
            r_next.state = ST_CONVERT;
            r_next.cnt   = CNT_W'(FIRST_CONV_CYC);
          end else begin
            r_next.powered = 1'b1;
            r_next.state   = ST_POWERUP;
            r_next.cnt     = CNT_W'(POWERUP_CYC);
          end
        end else if (r_reg.powered) begin
          // Idle count up; powerdown after the last idle cycle.
          if (r_reg.cnt == IDLE_LAST) begin
            r_next.powered = 1'b0;
            r_next.cnt     = CNT_ZERO;
          end else begin
            r_next.cnt = r_reg.cnt + CNT_ONE;
          end
        end
      end
      ST_POWERUP: begin
        if (startReq) begin
          r_next.cnt = CNT_W'(POWERUP_CYC);
        end else if (lastCycle) begin
          r_next.state = ST_CONVERT;
          r_next.cnt   = CNT_W'(FIRST_CONV_CYC);
        end else begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end
      end
      ST_CONVERT: begin
        if (startReq) begin
          // Restart throws away the running conversion.
          r_next.convEnable = 1'b1;
          r_next.firstDone  = 1'b0;
          r_next.cnt        = CNT_W'(FIRST_CONV_CYC);
        end else if (r_reg.firstDone && !r_reg.continuousMode) begin
          // Stopping drops the partial result, so no new interrupt appears.
          r_next.state = ST_IDLE;
          r_next.cnt   = CNT_ZERO;
        end else if (lastCycle) begin
          // Both bytes and the request move in one edge.
          r_next.resultHighByte = modResult[12:5];
          r_next.resultLowByte  = {modResult[4:0], 2'b00, modOverflow};
          r_next.irqPulse       = 1'b1;
          r_next.convEnable     = 1'b0;
          r_next.firstDone      = 1'b1;
          if (r_reg.continuousMode) begin
            r_next.cnt = CNT_W'(CONTINUOUS_MODE_CONV_CYC);
          end else begin
            r_next.state = ST_IDLE;
            r_next.cnt   = CNT_ZERO;
          end
        end else begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end
      end
    endcase

    // Read path: one cycle of wait, then data with waitrequest low.
    r_next.readValid = read && !r_reg.readValid;
    r_next.readData  = 32'h0000_0000;
    if (read && !r_reg.readValid) begin
      unique case (address)
        ADDR_CTRL0:   r_next.readData[7:0] = {r_reg.convEnable, r_reg.refLevelLowBit, r_reg.refPinOutputEnable,
                                              r_reg.continuousMode, r_reg.channelSelect};
        ADDR_CTRL1:   r_next.readData[7:0] = {r_reg.refLevelHighBit, 4'h0, r_reg.inputModeSelect};
        ADDR_RESHIGH: r_next.readData[7:0] = r_reg.resultHighByte;
        ADDR_RESLOW:  r_next.readData[7:0] = r_reg.resultLowByte;
        ADDR_STATUS: begin
          r_next.readData[STAT_POWERED_BIT] = r_reg.powered;
          r_next.readData[STAT_BUSY_BIT]    = (r_reg.state != ST_IDLE);
        end
        default:      r_next.readData = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r_reg                    <= '0;
      r_reg.state              <= ST_IDLE;
      r_reg.refLevelLowBit     <= CTRL0_RESET[CTRL0_REFLOW_BIT];
      r_reg.refLevelHighBit    <= CTRL1_RESET[CTRL1_REFHIGH_BIT];
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// ===== test/adc_conversion_sequencer_test.sv
// Self-checking bench of the conversion sequencer.
module adc_conversion_sequencer_test
  import adcseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           mclk, rstn, read, write, waitrequest, modOverflow, convDoneIrq;
  logic [2:0]     address;
  logic [31:0]    writedata, readdata;
  logic [12:0]    modResult, r;
  logic [7:0]     c0, c1, expRd[$];
  logic [3:0]     ch;
  adcseq_analog_t analogCtrl;
  int             errors, n_tests, cyc, acc, expIrq[$];
  adcseq_sequencer dut_u (.mclk(mclk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .modResult(modResult),
    .modOverflow(modOverflow), .analogCtrl(analogCtrl), .convDoneIrq(convDoneIrq));
  adcseq_mod_model mod_u (.analogCtrl(analogCtrl), .modResult(modResult), .modOverflow(modOverflow));
  // Clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Edge count gives expected times and cuts a hang short.
  // Non-blocking so a task sampling at the same edge always sees the count before that edge.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      errors++;
      wrap_up();
    end
  end
  // Results are taken at the falling edge, where they are settled.
  always @(negedge mclk) begin
    if (read && !waitrequest) cmp_rd(readdata, expRd.size() ? {24'h0, expRd.pop_front()} : 32'hDEAD);
    if (convDoneIrq === 1'b1) cmp_irq(cyc, expIrq.size() ? expIrq.pop_front() : 32'hFFFF_FFFF);
  end
  // Read data against the noted register value.
  task automatic cmp_rd(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: read %0h expected %0h", $time, got, exp);
    end
  endtask
  // Completion cycle against the noted cycle.
  task automatic cmp_irq(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: irq cycle %0h expected %0h", $time, got, exp);
    end
  endtask
  // Holds the request until the rising edge at which waitrequest is sampled low.
  task automatic bus(logic w, logic [2:0] a, logic [7:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !w;
    write <= w;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    acc = cyc;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    expRd.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wrap_up();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {errors, n_tests, cyc} = 0;
    {rstn, read, write, address, writedata} = 0;
    void'($urandom(93));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    bus(1'b1, 3'h6, 8'hFF);
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    for (int k = 0; k < 4; k++) begin
      c1 = 8'($urandom) & 8'h87;
      ch = k == 2 ? CHAN_OFFSET_CAL : k == 3 ? 4'hE : 4'($urandom_range(13));
      c0 = {1'b1, 1'($urandom), 2'b00, ch};
      bus(1'b1, ADDR_CTRL1, c1);
      rd(ADDR_CTRL1, c1);
      if (k != 1) begin
        repeat (170) @(posedge mclk);
        rd(ADDR_STATUS, 8'h00);
      end
      bus(1'b1, ADDR_CTRL0, c0);
      expIrq.push_back(acc + 5130 + (k != 1 ? 40 : 0));
      rd(ADDR_CTRL0, c0);
      if (k == 2) begin
        repeat (100) @(posedge mclk);
        bus(1'b1, ADDR_CTRL0, c0 & 8'h7F);
        rd(ADDR_CTRL0, c0);
        bus(1'b1, ADDR_CTRL0, c0);
        void'(expIrq.pop_back());
        expIrq.push_back(acc + 5130);
      end
      wait (expIrq.size() == 0);
      r = ch == CHAN_OFFSET_CAL ? 13'h1FF6 : {ch, c1[2:0], 6'h2B};
      rd(ADDR_CTRL0, c0 & 8'h7F);
      rd(ADDR_RESHIGH, r[12:5]);
      rd(ADDR_RESLOW, {r[4:0], 2'b00, ch == 4'hE});
      rd(ADDR_STATUS, 8'h01);
    end
    c0 = {4'h9, 4'($urandom_range(13))};
    bus(1'b1, ADDR_CTRL0, c0);
    for (int j = 0; j < 4; j++) expIrq.push_back(acc + 5130 + 256 * j);
    wait (expIrq.size() == 3);
    rd(ADDR_CTRL0, c0 & 8'h7F);
    bus(1'b1, ADDR_CTRL1, c1 ^ 8'h05);
    wait (expIrq.size() == 2);
    r = {c0[3:0], c1[2:0] ^ 3'h5, 6'h2B};
    rd(ADDR_RESHIGH, r[12:5]);
    wait (expIrq.size() == 0);
    bus(1'b1, ADDR_CTRL0, c0 & 8'h6F);
    repeat (600) @(posedge mclk);
    wrap_up();
  end
endmodule

// ===== test/adcseq_chk.sv
// Concurrent checks on the sequencer ports.
module adcseq_chk
  import adcseq_pkg::*;
(
  // Sequencer ports.
  input wire logic           mclk,
  input wire logic           rstn,
  input wire logic [2:0]     address,
  input wire logic           read,
  input wire logic           write,
  input wire logic [31:0]    writedata,
  input wire logic [31:0]    readdata,
  input wire logic           waitrequest,
  input wire logic [12:0]    modResult,
  input wire logic           modOverflow,
  input wire adcseq_analog_t analogCtrl,
  input wire logic           convDoneIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] sinceIrq;
  // Saturating gap since the last completion; reset reads as long ago.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      sinceIrq <= 13'h1FFF;
    else
      sinceIrq <= convDoneIrq ? 13'h0000 : sinceIrq + {12'h000, sinceIrq != 13'h1FFF};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_irq_pulse: assert property (convDoneIrq |=> !convDoneIrq)
    else $error("irq wider than one cycle");
  a_irq_gap: assert property (convDoneIrq |-> sinceIrq >= 13'h0FF)
    else $error("completions too close");
  a_idle_down: assert property ($fell(analogCtrl.powerOn) |-> sinceIrq >= 13'h09E)
    else $error("powerdown too early");
  a_conv_power: assert property (convDoneIrq |-> $past(analogCtrl.powerOn))
    else $error("completion while unpowered");
  a_write_ready: assert property (write |-> !waitrequest)
    else $error("write stalled");
  a_read_wait: assert property ($rose(read) |-> waitrequest ##1 (!waitrequest && readdata[31:8] == 24'h0))
    else $error("read answer out of step");
  a_chan_take: assert property (write && address == ADDR_CTRL0 |=>
    analogCtrl.channelSelect == $past(writedata[3:0]) && analogCtrl.refLevelLowBit == $past(writedata[6]))
    else $error("channel not taken");
  a_mode_take: assert property (write && address == ADDR_CTRL1 |=>
    analogCtrl.inputModeSelect == $past(writedata[2:0]) && analogCtrl.refLevelHighBit == $past(writedata[7]))
    else $error("mode not taken");
  a_offset_short: assert property (analogCtrl.offsetShort == (analogCtrl.channelSelect == CHAN_OFFSET_CAL))
    else $error("offset short wrong");
endmodule

bind adcseq_sequencer adcseq_chk chk_u (.mclk(mclk), .rstn(rstn), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .modResult(modResult), .modOverflow(modOverflow), .analogCtrl(analogCtrl), .convDoneIrq(convDoneIrq));

// ===== test/adcseq_mod_model.sv
// Behavioural modulator on the far side of the sequencer.
module adcseq_mod_model
  import adcseq_pkg::*;
(
  // Control from the sequencer.
  input wire adcseq_analog_t analogCtrl,
  // Raw result back.
  output logic [12:0]        modResult,
  output logic               modOverflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] v;
  // Shorted inputs give a small offset; unpowered output is garbage, not the last value.
  assign v = analogCtrl.offsetShort ? 13'h1FF6 : {analogCtrl.channelSelect, analogCtrl.inputModeSelect, 6'h2B};
  assign modResult = analogCtrl.powerOn ? v : ~v;
  assign modOverflow = analogCtrl.channelSelect == 4'hE;
endmodule
